// >>> rtl/phase_limit_and_fsw_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "phase_limit_map.vh"

module phase_limit_and_fsw_regs (
	input wire clock, // System clock, 200 MHz
	input wire rst, // Synchronous reset, active high
	input wire ce, // Clock enable, freezes all state when low
	input wire [7:0] regAddr, // Register offset from the serial slave
	input wire regWrEn, // Write strobe, one cycle
	input wire [7:0] regWrData, // Write data
	input wire regRdEn, // Read strobe, one cycle
	output reg [7:0] regRdData, // Read data, valid the cycle after regRdEn
	input wire [4:0] limitResistorCode, // Code sensed on the limit resistor pin
	input wire [7:0] phaseLimitActive, // Per-phase limiting level, bit 0 phase 1
	input wire [4:0] freqResistorCode, // Code sensed on the frequency resistor pin
	input wire limitSelectInternal, // Selection bit: use programmed threshold
	input wire freqSelectInternal, // Selection bit: use programmed frequency code
	input wire [3:0] activePhaseCount, // Phases in use, 1 to 8
	output reg [4:0] limitThresholdCode, // Threshold code in force
	output reg [10:0] limitThresholdMv, // Threshold in force, millivolts
	output reg [4:0] freqCode, // Frequency code in force
	output reg [15:0] switchingFreqKhz, // Switching frequency, kHz
	output reg freqSensed // High once the power-on frequency code is held
);

	// Threshold code to millivolts
	function [10:0] codeToMv;
		input [4:0] code;
		begin
			codeToMv = `LIMIT_BASE_MV + `LIMIT_STEP_MV * {6'h00, code};
		end
	endfunction

	// Phase count to table column, out-of-range counts clamp
	function [2:0] phaseToIndex;
		input [3:0] count;
		begin
			if (count == 4'h0) begin
				phaseToIndex = 3'h0;
			end else if (count > 4'h8) begin
				phaseToIndex = 3'h7;
			end else begin
				phaseToIndex = count[2:0] - 3'h1;
			end
		end
	endfunction

	// Code widened to a register byte, reserved bits zero
	function [7:0] padCode;
		input [4:0] code;
		begin
			padCode = {{`RSVD_W{1'b0}}, code};
		end
	endfunction

	// Synchronised pin levels
	wire [4:0] limitPinSync; // Settled limit resistor code
	wire [7:0] phaseLimitSync; // Settled per-phase limiting levels
	wire [4:0] freqPinSync; // Settled frequency resistor code
	wire [15:0] romFreqKhz; // Table output

	// Register state
	reg [7:0] limitFlags_reg; // Per-phase limit status flags
	reg [7:0] limitFlags_next; // Next flags
	reg [7:0] phaseLimitPrev_reg; // Previous limiting levels for edge detect
	reg [4:0] limitConfig_reg; // Programmed threshold code
	reg [4:0] limitSensed_reg; // Resistor-derived threshold code
	reg [4:0] freqSensed_reg; // Power-on sensed frequency code
	reg [4:0] freqConfig_reg; // Programmed frequency code
	reg [2:0] settleCnt_reg; // Cycles since reset release
	reg [4:0] activeLimit; // Threshold code chosen
	reg [4:0] activeFreq; // Frequency code chosen
	reg [7:0] readMux; // Read data selection

	// Decoded strobes
	wire wrLimitConfig; // Write to threshold configuration
	wire wrFreqConfig; // Write to frequency configuration
	wire rdFlags; // Read of the flag register
	wire [7:0] limitEntry; // Phases entering limiting this cycle

	assign wrLimitConfig = regWrEn && (regAddr == `OFS_LIMIT_THRESHOLD);
	assign wrFreqConfig = regWrEn && (regAddr == `OFS_FREQ_SELECT);
	assign rdFlags = regRdEn && (regAddr == `OFS_PHASE_LIMIT_FLAGS);
	assign limitEntry = phaseLimitSync & ~phaseLimitPrev_reg;

	// Limit resistor pin crossing
	pin_sync #(
		.WIDTH(5)
	) u_limitSync (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.asyncIn(limitResistorCode),
		.syncOut(limitPinSync)
	);

	// Per-phase limiting crossing
	pin_sync #(
		.WIDTH(8)
	) u_phaseSync (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.asyncIn(phaseLimitActive),
		.syncOut(phaseLimitSync)
	);

	// Frequency resistor pin crossing
	pin_sync #(
		.WIDTH(5)
	) u_freqSync (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.asyncIn(freqResistorCode),
		.syncOut(freqPinSync)
	);

	// Frequency lookup by active code and phase count
	freq_table_rom u_freqRom (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.code(activeFreq),
		.phaseIndex(phaseToIndex(activePhaseCount)),
		.freqKhz(romFreqKhz)
	);

	// Flag update: entries set, read clears, set beats clear
	always @* begin
		limitFlags_next = limitFlags_reg;
		if (rdFlags) begin
			limitFlags_next = `RST_FLAGS; // Cleared by the read
		end
		limitFlags_next = limitFlags_next | limitEntry;
	end

	// Source selection for the threshold and frequency code
	always @* begin
		if (limitSelectInternal) begin
			activeLimit = limitConfig_reg;
		end else begin
			activeLimit = limitSensed_reg;
		end
		if (freqSelectInternal) begin
			activeFreq = freqConfig_reg;
		end else begin
			activeFreq = freqSensed_reg;
		end
	end

	// Read data selection, reserved bits read zero
	always @* begin
		case (regAddr)
			`OFS_PHASE_LIMIT_FLAGS: begin
				readMux = limitFlags_reg;
			end
			`OFS_LIMIT_THRESHOLD: begin
				readMux = padCode(limitConfig_reg);
			end
			`OFS_FREQ_SENSED: begin
				readMux = padCode(freqSensed_reg);
			end
			`OFS_FREQ_SELECT: begin
				readMux = padCode(freqConfig_reg);
			end
			default: begin
				readMux = `RST_READ_DATA; // Unmapped offsets read zero
			end
		endcase
	end

	// Status flags and edge history
	always @(posedge clock) begin
		if (rst) begin
			limitFlags_reg <= `RST_FLAGS;
			phaseLimitPrev_reg <= `RST_FLAGS;
		end else if (ce) begin
			limitFlags_reg <= limitFlags_next;
			phaseLimitPrev_reg <= phaseLimitSync;
		end
	end

	// Host-written configuration registers
	always @(posedge clock) begin
		if (rst) begin
			limitConfig_reg <= `RST_LIMIT_CODE;
			freqConfig_reg <= `RST_FREQ_CODE;
		end else if (ce) begin
			if (wrLimitConfig) begin
				limitConfig_reg <= regWrData[`CODE_MSB:0];
			end
			if (wrFreqConfig) begin
				freqConfig_reg <= regWrData[`CODE_MSB:0];
			end
		end
	end

	// Resistor-derived threshold tracked every cycle
	always @(posedge clock) begin
		if (rst) begin
			limitSensed_reg <= `RST_LIMIT_CODE;
		end else if (ce) begin
			limitSensed_reg <= limitPinSync;
		end
	end

	// Power-on capture of the frequency code after the crossing settles
	always @(posedge clock) begin
		if (rst) begin
			settleCnt_reg <= 3'h0;
			freqSensed_reg <= `RST_FREQ_CODE;
			freqSensed <= 1'b0;
		end else if (ce) begin
			if (settleCnt_reg != `SENSE_SETTLE_CYCLES) begin
				settleCnt_reg <= settleCnt_reg + 3'h1;
			end else if (!freqSensed) begin
				freqSensed_reg <= freqPinSync & `EVEN_CODE_MASK;
				freqSensed <= 1'b1;
			end
		end
	end

	// Outputs in force and read data
	always @(posedge clock) begin
		if (rst) begin
			limitThresholdCode <= `RST_LIMIT_CODE;
			limitThresholdMv <= `LIMIT_BASE_MV;
			freqCode <= `RST_FREQ_CODE;
			switchingFreqKhz <= 16'h0000;
			regRdData <= `RST_READ_DATA;
		end else if (ce) begin
			limitThresholdCode <= activeLimit;
			limitThresholdMv <= codeToMv(activeLimit);
			freqCode <= activeFreq;
			switchingFreqKhz <= romFreqKhz;
			if (regRdEn) begin
				regRdData <= readMux;
			end
		end
	end

endmodule // phase_limit_and_fsw_regs

`default_nettype wire

// >>> include/phase_limit_map.vh
`ifndef PHASE_LIMIT_MAP_VH
`define PHASE_LIMIT_MAP_VH

// Register offsets
`define OFS_PHASE_LIMIT_FLAGS 8'h2D
`define OFS_LIMIT_THRESHOLD 8'h2E
`define OFS_FREQ_SENSED 8'h2F
`define OFS_FREQ_SELECT 8'h30

// Field layout
`define CODE_MSB 4
`define CODE_W 5
`define PHASE_COUNT 8
`define RSVD_W 3

// Reset values
`define RST_FLAGS 8'h00
`define RST_LIMIT_CODE 5'h00
`define RST_FREQ_CODE 5'h00
`define RST_READ_DATA 8'h00

// Threshold code to millivolts: base plus code times step
`define LIMIT_BASE_MV 11'h0C8
`define LIMIT_STEP_MV 11'h032

// Frequency resistor sensing reaches even codes only
`define EVEN_CODE_MASK 5'h1E

// Cycles after reset before the sensed code is trusted
`define SENSE_SETTLE_CYCLES 3'h4

`endif

// >>> rtl/pin_sync.v
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; output moves only when stages two and three agree
module pin_sync #(
	parameter WIDTH = 1
) (
	input wire clock, // System clock
	input wire rst, // Synchronous reset, active high
	input wire ce, // Clock enable, freezes state when low
	input wire [WIDTH-1:0] asyncIn, // Level from outside the clock domain
	output reg [WIDTH-1:0] syncOut // Settled, synchronised level
);

	reg [WIDTH-1:0] stage1_reg; // First stage, read by stage two only
	reg [WIDTH-1:0] stage2_reg; // Second stage
	reg [WIDTH-1:0] stage3_reg; // Third stage

	// Shift chain and agreement filter
	always @(posedge clock) begin
		if (rst) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
			stage3_reg <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else if (ce) begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			if (stage2_reg == stage3_reg) begin
				syncOut <= stage3_reg;
			end
		end
	end

endmodule // pin_sync

`default_nettype wire

// >>> rtl/freq_table_rom.v
`timescale 1ns/100ps
`default_nettype none

// Frequency lookup in kHz by code and active phase count, registered output
module freq_table_rom (
	input wire clock, // System clock
	input wire rst, // Synchronous reset, active high
	input wire ce, // Clock enable
	input wire [4:0] code, // Active frequency code
	input wire [2:0] phaseIndex, // Active phase count minus one
	output reg [15:0] freqKhz // Switching frequency in kHz
);

	reg [127:0] row; // Eight entries, phase 8 in the top word

	// Row per code, phase 8 first down to phase 1
	always @* begin
		case (code)
			5'h00: row = {16'h00DD, 16'h00FD, 16'h0127, 16'h0163,
				16'h00DD, 16'h0125, 16'h00DF, 16'h00E8};
			5'h01: row = {16'h00F4, 16'h0114, 16'h014A, 16'h018F,
				16'h00F4, 16'h0149, 16'h00F3, 16'h00FC};
			5'h02: row = {16'h010A, 16'h0135, 16'h0163, 16'h01A9,
				16'h010A, 16'h0166, 16'h0108, 16'h0110};
			5'h03: row = {16'h0125, 16'h0147, 16'h0183, 16'h01CC,
				16'h0125, 16'h017D, 16'h0126, 16'h0129};
			5'h04: row = {16'h0133, 16'h015F, 16'h019C, 16'h01F5,
				16'h0133, 16'h0197, 16'h013D, 16'h0142};
			5'h05: row = {16'h014D, 16'h0180, 16'h01B9, 16'h021E,
				16'h014D, 16'h01C2, 16'h014F, 16'h0154};
			5'h06: row = {16'h015F, 16'h0199, 16'h01E0, 16'h0231,
				16'h015F, 16'h01E0, 16'h0160, 16'h0169};
			5'h07: row = {16'h0175, 16'h01AF, 16'h01F3, 16'h0267,
				16'h0175, 16'h01FE, 16'h017C, 16'h0181};
			5'h08: row = {16'h018A, 16'h01C3, 16'h0210, 16'h027F,
				16'h018A, 16'h0212, 16'h018F, 16'h019D};
			5'h09: row = {16'h01A5, 16'h01E1, 16'h022F, 16'h02A4,
				16'h01A5, 16'h0232, 16'h01A4, 16'h01B3};
			5'h0A: row = {16'h01C1, 16'h01EF, 16'h0251, 16'h02D5,
				16'h01C1, 16'h0258, 16'h01B4, 16'h01C8};
			5'h0B: row = {16'h01D5, 16'h020D, 16'h0264, 16'h02EA,
				16'h01D5, 16'h0266, 16'h01C6, 16'h01DE};
			5'h0C: row = {16'h01DF, 16'h0233, 16'h027F, 16'h02F5,
				16'h01DF, 16'h0277, 16'h01E3, 16'h01F4};
			5'h0D: row = {16'h01FD, 16'h023A, 16'h02A9, 16'h031F,
				16'h01FD, 16'h0297, 16'h01FC, 16'h01FD};
			5'h0E: row = {16'h0206, 16'h024C, 16'h02B9, 16'h033F,
				16'h0206, 16'h02B0, 16'h020E, 16'h0206};
			5'h0F: row = {16'h021F, 16'h0269, 16'h02D2, 16'h036A,
				16'h021F, 16'h02D2, 16'h021F, 16'h021C};
			5'h10: row = {16'h0245, 16'h0299, 16'h030B, 16'h03A2,
				16'h0245, 16'h0315, 16'h0247, 16'h0242};
			5'h11: row = {16'h0289, 16'h02CE, 16'h0371, 16'h0413,
				16'h0289, 16'h035B, 16'h0290, 16'h027E};
			5'h12: row = {16'h02C4, 16'h0316, 16'h03A9, 16'h0469,
				16'h02C4, 16'h03A2, 16'h02BA, 16'h02BA};
			5'h13: row = {16'h02EF, 16'h0364, 16'h03F2, 16'h04BB,
				16'h02EF, 16'h03F2, 16'h0303, 16'h02F6};
			5'h14: row = {16'h031F, 16'h0396, 16'h0431, 16'h04FE,
				16'h031F, 16'h0447, 16'h0327, 16'h0332};
			5'h15: row = {16'h0362, 16'h03EB, 16'h0470, 16'h055C,
				16'h0362, 16'h047B, 16'h035C, 16'h036E};
			5'h16: row = {16'h0397, 16'h0401, 16'h04C4, 16'h05A9,
				16'h0397, 16'h04D1, 16'h0383, 16'h03AA};
			5'h17: row = {16'h03C4, 16'h0457, 16'h0511, 16'h05FD,
				16'h03C4, 16'h04EC, 16'h03B6, 16'h03CC};
			5'h18: row = {16'h03E1, 16'h0474, 16'h053B, 16'h1A3C,
				16'h03E1, 16'h053D, 16'h03EB, 16'h03F6};
			5'h19: row = {16'h0423, 16'h04AE, 16'h059E, 16'h0697,
				16'h0423, 16'h055C, 16'h041C, 16'h042B};
			5'h1A: row = {16'h044A, 16'h04EE, 16'h05CD, 16'h06C6,
				16'h044A, 16'h05AA, 16'h0448, 16'h0452};
			5'h1B: row = {16'h0475, 16'h050F, 16'h05FD, 16'h071D,
				16'h0475, 16'h0603, 16'h0482, 16'h0483};
			5'h1C: row = {16'h04B0, 16'h053A, 16'h0633, 16'h1D6A,
				16'h04B0, 16'h0653, 16'h04B5, 16'h04B1};
			5'h1D: row = {16'h04D4, 16'h057D, 16'h0648, 16'h07A2,
				16'h04D4, 16'h0652, 16'h04CB, 16'h04DD};
			5'h1E: row = {16'h050B, 16'h05B3, 16'h06AB, 16'h07DC,
				16'h050B, 16'h068A, 16'h04FA, 16'h0500};
			default: row = {16'h0520, 16'h05D5, 16'h06BC, 16'h0830,
				16'h0520, 16'h06BC, 16'h0524, 16'h0532};
		endcase
	end

	// Registered read of the selected phase column
	always @(posedge clock) begin
		if (rst) begin
			freqKhz <= 16'h0000;
		end else if (ce) begin
			freqKhz <= row[{phaseIndex, 4'h0} +: 16];
		end
	end

endmodule // freq_table_rom

`default_nettype wire

// >>> sim/regs_checker_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the limit and frequency register slice
module regs_checker (
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire logic ce, // Clock enable
	input wire logic [7:0] regAddr, // Offset
	input wire logic regWrEn, // Write strobe
	input wire logic [7:0] regWrData, // Write data
	input wire logic regRdEn, // Read strobe
	input wire logic [7:0] regRdData, // Read data
	input wire logic [4:0] limitResistorCode, // Resistor code
	input wire logic limitSelectInternal, // Limit select
	input wire logic freqSelectInternal, // Frequency select
	input wire logic [3:0] activePhaseCount, // Phases in use
	input wire logic [4:0] limitThresholdCode, // Code in force
	input wire logic [10:0] limitThresholdMv, // Millivolts
	input wire logic [4:0] freqCode, // Frequency code
	input wire logic [15:0] switchingFreqKhz, // Frequency in kHz
	input wire logic freqSensed // Power-on code held
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_mv_linear: assert property (limitThresholdMv == 11'h0C8 + 11'h032 * limitThresholdCode)
		else $error("threshold millivolts off the line");
	a_limit_sel: assert property (regWrEn && regAddr == 8'h2E ##1 limitSelectInternal && !regWrEn
		|=> {3'h0, limitThresholdCode} == ($past(regWrData, 2) & 8'h1F))
		else $error("programmed threshold not applied");
	a_freq_sel: assert property (regWrEn && regAddr == 8'h30 ##1 freqSelectInternal && !regWrEn
		|=> {3'h0, freqCode} == ($past(regWrData, 2) & 8'h1F))
		else $error("programmed frequency code not applied");
	a_freq_table: assert property (freqSensed && activePhaseCount == 4'h8 && $stable(freqCode)
		&& $stable(activePhaseCount) && (freqCode == 5'h00 || freqCode == 5'h1F)
		|=> switchingFreqKhz == ($past(freqCode) == 5'h00 ? 16'h00DD : 16'h0520))
		else $error("eight-phase frequency wrong");
	a_rsvd_zero: assert property (regRdEn && regAddr >= 8'h2E && regAddr <= 8'h30
		|=> regRdData[7:5] == 3'h0)
		else $error("reserved bits read nonzero");
	a_rd_holds: assert property (!regRdEn |=> $stable(regRdData))
		else $error("read data moved without a read");
	a_sensed_even: assert property (freqSensed && !$past(freqSelectInternal)
		|-> freqCode[0] == 1'b0)
		else $error("sensed frequency code is odd");
	a_sense_time: assert property ($fell(rst) |-> ##[4:7] freqSensed)
		else $error("power-on frequency code not captured");
	a_limit_default: assert property ((!limitSelectInternal && ce && $stable(limitResistorCode)) [*8]
		|-> limitThresholdCode == limitResistorCode)
		else $error("threshold does not follow resistor");
endmodule // regs_checker
bind phase_limit_and_fsw_regs regs_checker chk (.clock, .rst, .ce, .regAddr, .regWrEn, .regWrData,
	.regRdEn, .regRdData, .limitResistorCode, .limitSelectInternal, .freqSelectInternal,
	.activePhaseCount, .limitThresholdCode, .limitThresholdMv, .freqCode, .switchingFreqKhz,
	.freqSensed);
`default_nettype wire

// >>> sim/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the register port; changes only after a rising edge
module host_model (
	input wire logic clock, // Clock
	input wire logic [7:0] regRdData, // Read data
	output var logic [7:0] regAddr, // Offset
	output var logic regWrEn, // Write strobe
	output var logic [7:0] regWrData, // Write data
	output var logic regRdEn // Read strobe
);
	// Idle bus at time zero
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end
	// One-cycle write; released write data shows the inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clock);
		regWrEn <= 1'b0;
		regWrData <= ~d;
	endtask
	// One-cycle read; registered data is taken at the edge after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clock);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		@(posedge clock);
		d = regRdData;
	endtask
endmodule // host_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clock = 1'b0; // Clock
	logic rst = 1'b1; // Reset
	logic ce = 1'b1; // Clock enable, driven low during t_enable
	logic [4:0] limitResistorCode = 5'h0A; // Limit pin code
	logic [7:0] phaseLimitActive = 8'h00; // Phase limiting
	logic [4:0] freqResistorCode = 5'h15; // Odd pin code
	logic limitSelectInternal = 1'b0; // Limit select
	logic freqSelectInternal = 1'b0; // Frequency select
	logic [3:0] activePhaseCount = 4'h8; // Phases in use
	logic [7:0] regAddr, regWrData, regRdData; // Register bus
	logic regWrEn, regRdEn; // Strobes
	logic [4:0] limitThresholdCode, freqCode; // Codes in force
	logic [10:0] limitThresholdMv; // Millivolts
	logic [15:0] switchingFreqKhz; // kHz
	logic freqSensed; // Power-on code held
	int miscompares = 0; // Mismatches
	int n_tests = 0; // Comparisons
	int cyc = 0; // Cycle count
	always #2.5 clock = ~clock;
	host_model host (.clock, .regRdData, .regAddr, .regWrEn, .regWrData, .regRdEn);
	phase_limit_and_fsw_regs uut (.clock, .rst, .ce, .regAddr, .regWrEn, .regWrData, .regRdEn,
		.regRdData, .limitResistorCode, .phaseLimitActive, .freqResistorCode,
		.limitSelectInternal, .freqSelectInternal, .activePhaseCount, .limitThresholdCode,
		.limitThresholdMv, .freqCode, .switchingFreqKhz, .freqSensed);
	// Compare and count
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Verdict and end of run
	task automatic give_verdict;
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			miscompares++;
			give_verdict;
		end
	end
	// Sensed code after power-on
	task automatic t_power_on;
		logic [7:0] d;
		chk(16'(freqSensed), 16'h0001);
		@(posedge clock) freqResistorCode <= 5'h1E;
		wt(8);
		host.rd(8'h2F, d);
		chk(16'(d), 16'h0014);
		chk(16'(freqCode), 16'h0014);
		chk(switchingFreqKhz, 16'h031F);
		host.rd(8'h2D, d);
		chk(16'(d), 16'h0000);
	endtask
	// Resistor threshold, then programmed override
	task automatic t_limit;
		logic [7:0] d;
		@(posedge clock) limitResistorCode <= 5'h03;
		wt(10);
		chk(16'(limitThresholdCode), 16'h0003);
		chk(16'(limitThresholdMv), 16'h015E);
		host.wr(8'h2E, 8'hFF);
		host.rd(8'h2E, d);
		chk(16'(d), 16'h001F);
		chk(16'(limitThresholdCode), 16'h0003);
		@(posedge clock) limitSelectInternal <= 1'b1;
		wt(3);
		chk(16'(limitThresholdMv), 16'h06D6);
		host.wr(8'h2E, 8'h00);
		wt(3);
		chk(16'(limitThresholdMv), 16'h00C8);
		@(posedge clock) limitSelectInternal <= 1'b0;
	endtask
	// Programmed frequency code and table
	task automatic t_freq;
		logic [7:0] d;
		host.wr(8'h30, 8'hFF);
		host.wr(8'h2F, 8'h03);
		host.rd(8'h30, d);
		chk(16'(d), 16'h001F);
		host.rd(8'h2F, d);
		chk(16'(d), 16'h0014);
		chk(16'(freqCode), 16'h0014);
		@(posedge clock) freqSelectInternal <= 1'b1;
		wt(4);
		chk(16'(freqCode), 16'h001F);
		chk(switchingFreqKhz, 16'h0520);
		host.wr(8'h30, 8'h00);
		@(posedge clock) activePhaseCount <= 4'h1;
		wt(4);
		chk(switchingFreqKhz, 16'h00E8);
		@(posedge clock) activePhaseCount <= 4'h0;
		wt(4);
		chk(switchingFreqKhz, 16'h00E8);
		@(posedge clock) activePhaseCount <= 4'hF;
		wt(4);
		chk(switchingFreqKhz, 16'h00DD);
		@(posedge clock) activePhaseCount <= 4'h8;
		wt(4);
		chk(switchingFreqKhz, 16'h00DD);
		@(posedge clock) freqSelectInternal <= 1'b0;
		host.rd(8'h31, d);
		chk(16'(d), 16'h0000);
	endtask
	// Each phase in turn sets only its own flag
	task automatic t_flags;
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) phaseLimitActive <= 8'h01 << i;
			wt(8);
			host.rd(8'h2D, d);
			chk(16'(d), 16'h0001 << i);
			host.rd(8'h2D, d);
			chk(16'(d), 16'h0000);
		end
		@(posedge clock) phaseLimitActive <= 8'h00;
		wt(8);
		// New entries on the edge of a clearing read must survive it
		@(posedge clock) phaseLimitActive <= 8'h81;
		wt(3);
		host.rd(8'h2D, d);
		chk(16'(d), 16'h0000);
		host.rd(8'h2D, d);
		chk(16'(d), 16'h0081);
		@(posedge clock) phaseLimitActive <= 8'h00;
	endtask
	// Clock enable low freezes the crossing and the outputs
	task automatic t_enable;
		@(posedge clock);
		ce <= 1'b0;
		limitResistorCode <= 5'h07;
		wt(10);
		chk(16'(limitThresholdCode), 16'h0003);
		@(posedge clock) ce <= 1'b1;
		wt(10);
		chk(16'(limitThresholdCode), 16'h0007);
		chk(16'(limitThresholdMv), 16'h0226);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		wt(12);
		t_power_on;
		t_limit;
		t_freq;
		t_flags;
		t_enable;
		give_verdict;
	end
endmodule // tb_top
`default_nettype wire
